// ---- rtl/ptw_pkg.sv ----
// constants for the periodic tick timer and watchdog block
`default_nettype none
package ptw_pkg;
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned TICK_BASE_NS = 10000; // 10 us
    localparam int unsigned TICK_BASE_CYCLES = TICK_BASE_NS / CLK_PERIOD_NS;
    localparam int unsigned WDT_BASE_NS = 1000000; // 1 ms
    localparam int unsigned WDT_BASE_CYCLES = WDT_BASE_NS / CLK_PERIOD_NS;
    localparam int TICK_PRE_W = 11;
    localparam int WDT_PRE_W = 17;
    localparam logic [7:0] ADDR_TICK_INTERVAL = 8'hf6;
    localparam logic [7:0] ADDR_WDT_CSR = 8'hfb;
    localparam logic [7:0] INTERVAL_RESET = 8'h00;
    localparam logic [7:0] WDT_LIMIT = 8'h80; // 128 ms
    localparam logic [5:0] WDT_DISABLE_KEY = 6'h2a; // 101010
    localparam logic WDT_EN_RESET = 1'b1;
    localparam int WDT_KICK_BIT = 0;
    localparam int WDT_KEY_LSB = 1;
    localparam int WDT_KEY_MSB = 6;
    localparam int WDT_FLAG_BIT = 7;
endpackage
`default_nettype wire

// ---- rtl/ptw_timer.sv ----
// periodic tick timer and watchdog behind the core's register port
`default_nettype none
module ptw_timer #(
    parameter int unsigned WDT_BASE_CYCLES = ptw_pkg::WDT_BASE_CYCLES
) (
    input wire logic clk, // 125 mhz system clock
    input wire logic sys_rst, // power-up reset, sync, high
    input wire logic usb_rst, // usb bus reset, high
    input wire logic usb_reset_link_enable, // lets usb reset clear tick
    input wire logic tick_irq_enable, // tick interrupt enable bit
    input wire logic debug_enable, // debugger logic enabled
    input wire logic break_detect, // debugger break seen, pulse
    input wire logic jump_to_app, // jump-to-application done, pulse
    input wire logic [7:0] sfr_addr, // register address
    input wire logic sfr_wr, // write strobe, one cycle
    input wire logic sfr_rd, // read strobe, one cycle
    input wire logic [7:0] sfr_wdata, // write data
    output logic [7:0] sfr_rdata, // read data, one cycle after sfr_rd
    output logic tick_irq_line, // tick interrupt, one-cycle pulse
    output logic wdt_reset_out // watchdog reset to core, pulse
);
    localparam logic [ptw_pkg::TICK_PRE_W-1:0] TICK_PRE_LAST =
        ptw_pkg::TICK_PRE_W'(ptw_pkg::TICK_BASE_CYCLES - 1);
    localparam logic [ptw_pkg::WDT_PRE_W-1:0] WDT_PRE_LAST =
        ptw_pkg::WDT_PRE_W'(WDT_BASE_CYCLES - 1);

    logic [7:0] interval_reg, interval_next;
    logic [7:0] tcnt_reg, tcnt_next;
    logic [ptw_pkg::TICK_PRE_W-1:0] tpre_reg, tpre_next;
    logic irq_reg, irq_next;
    logic wdt_en_reg, wdt_en_next;
    logic susp_reg, susp_next;
    logic flag_reg, flag_next;
    logic [7:0] wcnt_reg, wcnt_next;
    logic [ptw_pkg::WDT_PRE_W-1:0] wpre_reg, wpre_next;
    logic wrst_reg, wrst_next;
    logic [7:0] rdata_reg, rdata_next;
    logic wr_tick, wr_csr, kick, key_hit, flag_clr, tick_clr;

    // decoded register writes
    assign wr_tick = sfr_wr && (sfr_addr == ptw_pkg::ADDR_TICK_INTERVAL);
    assign wr_csr = sfr_wr && (sfr_addr == ptw_pkg::ADDR_WDT_CSR);
    assign kick = wr_csr && sfr_wdata[ptw_pkg::WDT_KICK_BIT];
    assign key_hit = wr_csr && (sfr_wdata[ptw_pkg::WDT_KEY_MSB:
        ptw_pkg::WDT_KEY_LSB] == ptw_pkg::WDT_DISABLE_KEY);
    assign flag_clr = wr_csr && sfr_wdata[ptw_pkg::WDT_FLAG_BIT];
    // own watchdog reset always clears; usb reset only when linked
    assign tick_clr = wrst_reg || (usb_rst && usb_reset_link_enable);

    ////////////////////////////////////////////////////////////////////////
    // tick timer next state
    always_comb begin
        interval_next = interval_reg;
        tcnt_next = tcnt_reg;
        tpre_next = tpre_reg;
        irq_next = 1'b0;
        if (tick_clr) begin
            interval_next = ptw_pkg::INTERVAL_RESET;
            tcnt_next = ptw_pkg::INTERVAL_RESET;
            tpre_next = '0;
        end else if (wr_tick) begin
            // restart immediately, old count and timebase phase lost
            interval_next = sfr_wdata;
            tcnt_next = sfr_wdata;
            tpre_next = '0;
        end else if (interval_reg == ptw_pkg::INTERVAL_RESET) begin
            tpre_next = '0;
        end else if (tpre_reg == TICK_PRE_LAST) begin
            tpre_next = '0;
            if (tcnt_reg <= 8'h01) begin
                tcnt_next = interval_reg;
                irq_next = tick_irq_enable;
            end else begin
                tcnt_next = tcnt_reg - 8'h01;
            end
        end else begin
            tpre_next = tpre_reg + 1'b1;
        end
    end

    // tick timer registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            interval_reg <= ptw_pkg::INTERVAL_RESET;
            tcnt_reg <= ptw_pkg::INTERVAL_RESET;
            tpre_reg <= '0;
            irq_reg <= 1'b0;
        end else begin
            interval_reg <= interval_next;
            tcnt_reg <= tcnt_next;
            tpre_reg <= tpre_next;
            irq_reg <= irq_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // watchdog next state; a disabled watchdog cannot be re-armed by
    // software, only power-up reset brings it back
    always_comb begin
        wdt_en_next = wdt_en_reg && !key_hit;
        susp_next = susp_reg;
        if (debug_enable && break_detect) begin
            susp_next = 1'b1;
        end else if (jump_to_app) begin
            susp_next = 1'b0;
        end
        // set wins over a clear in the same cycle
        flag_next = wrst_reg || (flag_reg && !flag_clr);
        wcnt_next = wcnt_reg;
        wpre_next = wpre_reg;
        wrst_next = 1'b0;
        if (kick || !wdt_en_reg) begin
            wcnt_next = '0;
            wpre_next = '0;
        end else if (wcnt_reg == ptw_pkg::WDT_LIMIT) begin
            wrst_next = 1'b1;
            wcnt_next = '0;
            wpre_next = '0;
        end else if (!susp_reg) begin
            if (wpre_reg == WDT_PRE_LAST) begin
                wpre_next = '0;
                wcnt_next = wcnt_reg + 8'h01;
            end else begin
                wpre_next = wpre_reg + 1'b1;
            end
        end
    end

    // watchdog registers; usb reset deliberately not wired in here
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wdt_en_reg <= ptw_pkg::WDT_EN_RESET;
            susp_reg <= 1'b0;
            flag_reg <= 1'b0;
            wcnt_reg <= '0;
            wpre_reg <= '0;
            wrst_reg <= 1'b0;
        end else begin
            wdt_en_reg <= wdt_en_next;
            susp_reg <= susp_next;
            flag_reg <= flag_next;
            wcnt_reg <= wcnt_next;
            wpre_reg <= wpre_next;
            wrst_reg <= wrst_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read path; a read has no side effect on the watchdog
    always_comb begin
        rdata_next = '0;
        if (sfr_rd) begin
            case (sfr_addr)
                ptw_pkg::ADDR_TICK_INTERVAL: rdata_next = interval_reg;
                ptw_pkg::ADDR_WDT_CSR: begin
                    rdata_next[ptw_pkg::WDT_FLAG_BIT] = flag_reg;
                    rdata_next[ptw_pkg::WDT_KICK_BIT] = wdt_en_reg;
                end // key bits stay zero
                default: rdata_next = '0;
            endcase
        end
    end

    // read data register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata_reg <= '0;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign sfr_rdata = rdata_reg;
    assign tick_irq_line = irq_reg;
    assign wdt_reset_out = wrst_reg;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_tick_gate;
        tick_irq_line |-> $past(tick_irq_enable) && $past(tcnt_reg) <= 8'h01
            && $past(interval_reg) != 8'h00;
    endproperty
    a_tick_gate: assert property (p_tick_gate)
        else $error("tick pulse without enable or interval");

    property p_tick_restart;
        wr_tick && !tick_clr |=> tcnt_reg == $past(sfr_wdata)
            && tpre_reg == '0;
    endproperty
    a_tick_restart: assert property (p_tick_restart)
        else $error("interval write did not restart count");

    property p_tick_hold;
        !wr_tick && !tick_clr && tpre_reg != TICK_PRE_LAST
            |=> $stable(tcnt_reg);
    endproperty
    a_tick_hold: assert property (p_tick_hold)
        else $error("tick count moved between timebase ticks");

    property p_tick_clear;
        usb_rst && usb_reset_link_enable ##1 1'b1 |-> interval_reg == 8'h00;
    endproperty
    a_tick_clear: assert property (p_tick_clear)
        else $error("linked usb reset did not clear interval");

    property p_wdt_timeout;
        wcnt_reg == ptw_pkg::WDT_LIMIT && wdt_en_reg && !kick
            |=> wdt_reset_out ##1 flag_reg;
    endproperty
    a_wdt_timeout: assert property (p_wdt_timeout)
        else $error("watchdog limit without reset and flag");

    property p_wdt_kick;
        kick |=> wcnt_reg == 8'h00 && !wdt_reset_out;
    endproperty
    a_wdt_kick: assert property (p_wdt_kick)
        else $error("kick did not clear watchdog");

    property p_wdt_pause;
        susp_reg && !kick && wcnt_reg != ptw_pkg::WDT_LIMIT
            |=> $stable(wcnt_reg);
    endproperty
    a_wdt_pause: assert property (p_wdt_pause)
        else $error("watchdog counted while paused");

    property p_wdt_key;
        key_hit |=> !wdt_en_reg ##1 !wdt_en_reg;
    endproperty
    a_wdt_key: assert property (p_wdt_key)
        else $error("key did not disable watchdog");

    property p_key_read;
        sfr_rd && sfr_addr == ptw_pkg::ADDR_WDT_CSR
            |=> sfr_rdata[6:1] == 6'h00 && sfr_rdata[0] == $past(wdt_en_reg);
    endproperty
    a_key_read: assert property (p_key_read)
        else $error("csr read shows key bits or wrong enable");

    property p_en_after_rst;
        $past(sys_rst) |-> wdt_en_reg && !flag_reg;
    endproperty
    a_en_after_rst: assert property (p_en_after_rst)
        else $error("watchdog not enabled after power-up reset");

    property p_usb_keeps_csr;
        usb_rst && !key_hit |=> wdt_en_reg == $past(wdt_en_reg);
    endproperty
    a_usb_keeps_csr: assert property (p_usb_keeps_csr)
        else $error("usb reset changed watchdog enable");

    property p_read_no_kick;
        sfr_rd && !sfr_wr && wdt_en_reg && !susp_reg
            && wcnt_reg != ptw_pkg::WDT_LIMIT && wpre_reg == WDT_PRE_LAST
            |=> wcnt_reg == $past(wcnt_reg) + 8'h01;
    endproperty
    a_read_no_kick: assert property (p_read_no_kick)
        else $error("read disturbed watchdog count");

    property p_tick_reload;
        tpre_reg == TICK_PRE_LAST && tcnt_reg <= 8'h01 && !wr_tick
            && !tick_clr && interval_reg != ptw_pkg::INTERVAL_RESET
            |=> tcnt_reg == $past(interval_reg)
            && tick_irq_line == $past(tick_irq_enable);
    endproperty
    a_tick_reload: assert property (p_tick_reload)
        else $error("count at zero did not reload and pulse");

    property p_tick_off;
        interval_reg == ptw_pkg::INTERVAL_RESET && !wr_tick
            |=> !tick_irq_line && tpre_reg == '0;
    endproperty
    a_tick_off: assert property (p_tick_off)
        else $error("tick timer ran with zero interval");

    property p_wdt_pulse;
        wdt_reset_out |-> wcnt_reg == 8'h00 ##1 !wdt_reset_out
            && interval_reg == ptw_pkg::INTERVAL_RESET && flag_reg;
    endproperty
    a_wdt_pulse: assert property (p_wdt_pulse)
        else $error("watchdog reset pulse malformed or tick not cleared");

    property p_flag_clear;
        flag_clr && !wdt_reset_out |=> !flag_reg;
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("write of one did not clear reset cause");

    property p_flag_hold;
        !flag_clr && !wdt_reset_out |=> flag_reg == $past(flag_reg);
    endproperty
    a_flag_hold: assert property (p_flag_hold)
        else $error("reset cause changed without event or clear");

    property p_susp_set;
        debug_enable && break_detect |=> susp_reg;
    endproperty
    a_susp_set: assert property (p_susp_set)
        else $error("debug break did not pause watchdog");

    property p_susp_hold;
        !(debug_enable && break_detect) && !jump_to_app
            |=> susp_reg == $past(susp_reg);
    endproperty
    a_susp_hold: assert property (p_susp_hold)
        else $error("watchdog pause changed without break or jump");

    property p_wdt_off_still;
        !wdt_en_reg |=> !wdt_en_reg && wcnt_reg == 8'h00 && !wdt_reset_out;
    endproperty
    a_wdt_off_still: assert property (p_wdt_off_still)
        else $error("disabled watchdog counted or fired");
endmodule // ptw_timer
`default_nettype wire

// ---- test/ptw_core_model.sv ----
// core-side model driving the special function register port
`default_nettype none
module ptw_core_model (
    input wire logic clk, // system clock
    output logic [7:0] sfr_addr, // register address
    output logic sfr_wr, // write strobe
    output logic sfr_rd, // read strobe
    output logic [7:0] sfr_wdata, // write data
    input wire logic [7:0] sfr_rdata // read data
);
    timeunit 1ns;
    timeprecision 1ns;
    // idle bus at time zero
    initial begin
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
    end
    // one access; idle lines flip so stale data never passes for valid
    task automatic acc(input logic w, input logic [7:0] a,
            input logic [7:0] d, output logic [7:0] q);
        @(posedge clk);
        #1;
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = w;
        sfr_rd = !w;
        @(posedge clk);
        #1;
        q = sfr_rdata;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        sfr_addr = ~a;
        sfr_wdata = ~d;
    endtask
endmodule // ptw_core_model
`default_nettype wire

// ---- test/ptw_timer_tb.sv ----
// self-checking bench for the tick timer and watchdog
`default_nettype none
`define CHK(nm, ex, sn) begin num_checks++; if ((ex) !== (sn)) begin \
    err_count++; $display("wrong value %s exp %0h got %0h", nm, ex, sn); \
    end end
module ptw_timer_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int WB = 4; // shortened 1 ms timebase
    localparam int TB = ptw_pkg::TICK_BASE_CYCLES;
    logic clk = 1'b0, sys_rst = 1'b1, usb_rst = 1'b0, link_en = 1'b0;
    logic irq_en = 1'b0, dbg_en = 1'b0, brk = 1'b0, jmp = 1'b0;
    logic [7:0] addr, wdata, rdata, q;
    logic wr, rd, irq, wdt;
    int err_count = 0, num_checks = 0, cyc = 0, hits = 0, n, k;
    int tq[$];
    logic [7:0] m_int = 8'h00; // reference interval
    logic m_en = 1'b1, m_flag = 1'b0; // reference enable and cause
    ptw_core_model core_u (.clk(clk), .sfr_addr(addr), .sfr_wr(wr),
        .sfr_rd(rd), .sfr_wdata(wdata), .sfr_rdata(rdata));
    ptw_timer #(.WDT_BASE_CYCLES(WB)) dut_u (.clk(clk), .sys_rst(sys_rst),
        .usb_rst(usb_rst), .usb_reset_link_enable(link_en),
        .tick_irq_enable(irq_en), .debug_enable(dbg_en),
        .break_detect(brk), .jump_to_app(jmp), .sfr_addr(addr),
        .sfr_wr(wr), .sfr_rd(rd), .sfr_wdata(wdata),
        .sfr_rdata(rdata), .tick_irq_line(irq), .wdt_reset_out(wdt));
    initial forever #4 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////
    // cycle count, pulse log, reference timeout effects, hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (irq === 1'b1) tq.push_back(cyc);
        if (wdt === 1'b1) begin
            hits <= hits + 1;
            m_flag <= 1'b1;
            m_int <= 8'h00;
        end
        if (cyc == 60000) begin
            err_count++;
            summarize();
        end
    end
    task automatic step(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask
    // write and mirror the effect into the reference
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        core_u.acc(1'b1, a, d, q);
        if (a == ptw_pkg::ADDR_TICK_INTERVAL) m_int = d;
        if (a == ptw_pkg::ADDR_WDT_CSR && d[7]) m_flag = 1'b0;
        if (a == ptw_pkg::ADDR_WDT_CSR && d[6:1] == 6'h2a) m_en = 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a);
        logic [7:0] e;
        e = 8'h00;
        if (a == ptw_pkg::ADDR_TICK_INTERVAL) e = m_int;
        if (a == ptw_pkg::ADDR_WDT_CSR) e = {m_flag, 6'h00, m_en};
        core_u.acc(1'b0, a, 8'h00, q);
        `CHK("sfr_rdata", e, q)
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // main sequence: watchdog first, ticks after it is keyed off
    initial begin
        void'($urandom(26680));
        step(12);
        sys_rst = 1'b0;
        rd_chk(8'hf6);
        rd_chk(8'hfb);
        rd_chk(8'h55);
        repeat (6) begin
            step(300);
            wr_reg(8'hfb, 8'h01);
        end
        `CHK("wdt_hits", 0, hits)
        wr_reg(8'hf6, 8'($urandom_range(255, 1)));
        wr_reg(8'hfb, 8'h01);
        wr_reg(8'hfb, 8'h56);
        // break with debug logic off must not pause the watchdog
        brk = 1'b1;
        step(1);
        brk = 1'b0;
        repeat (80) rd_chk(8'hfb);
        step(330);
        `CHK("wdt_hits", 0, hits)
        step(40);
        `CHK("wdt_hits", 1, hits)
        rd_chk(8'hfb);
        rd_chk(8'hf6);
        for (int i = 0; i < 2; i++) begin
            link_en = i[0];
            wr_reg(8'hf6, 8'($urandom_range(255, 1)));
            usb_rst = 1'b1;
            step(2);
            usb_rst = 1'b0;
            if (link_en) m_int = 8'h00;
            rd_chk(8'hf6);
            rd_chk(8'hfb);
        end
        wr_reg(8'hfb, 8'h01);
        rd_chk(8'hfb);
        wr_reg(8'hfb, 8'h81);
        rd_chk(8'hfb);
        // break freezes the count until the jump
        dbg_en = 1'b1;
        brk = 1'b1;
        step(1);
        brk = 1'b0;
        step(1000);
        `CHK("wdt_hits", 1, hits)
        jmp = 1'b1;
        step(1);
        jmp = 1'b0;
        step(540);
        `CHK("wdt_hits", 2, hits)
        wr_reg(8'hfb, 8'h54);
        rd_chk(8'hfb);
        step(1500);
        `CHK("wdt_hits", 2, hits)
        // periodic ticks with a random interval
        irq_en = 1'b1;
        n = $urandom_range(3, 1);
        tq.delete();
        wr_reg(8'hf6, 8'(n));
        k = cyc;
        step(3 * n * TB + 10);
        `CHK("tick_count", 3, tq.size())
        `CHK("tick_first", n * TB, tq[0] - k)
        `CHK("tick_period", n * TB, tq[2] - tq[1])
        // a rewrite mid-count restarts from the new value
        wr_reg(8'hf6, 8'h02);
        step(700);
        tq.delete();
        wr_reg(8'hf6, 8'h01);
        k = cyc;
        step(TB + 5);
        `CHK("tick_restart", TB, tq[0] - k)
        irq_en = 1'b0;
        step(2);
        tq.delete();
        step(2 * TB);
        `CHK("tick_gated", 0, tq.size())
        wr_reg(8'hf6, 8'h00);
        irq_en = 1'b1;
        tq.delete();
        step(2 * TB);
        `CHK("tick_off", 0, tq.size())
        // power-up reset restores the control register
        sys_rst = 1'b1;
        step(2);
        sys_rst = 1'b0;
        m_en = 1'b1;
        m_flag = 1'b0;
        m_int = 8'h00;
        rd_chk(8'hfb);
        rd_chk(8'hf6);
        summarize();
    end
endmodule // ptw_timer_tb
`default_nettype wire
